//--- pkg/rsd_pkg.sv
// constants for the reader status display register bank
package rsd_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PAGE    = 8'h29;
   localparam logic [7:0] IDX_GAIN    = 8'h2a;
   localparam logic [7:0] IDX_RSSI    = 8'h2b;
   localparam logic [7:0] IDX_CAL     = 8'h2c;
   localparam logic [7:0] IDX_IRQ_ST  = 8'h30;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h31;
   localparam logic [1:0] WORD_ALIGN  = 2'h0;

   localparam logic [7:0] PAGE_RESET  = 8'h00;
   localparam logic [3:0] MASK_RESET  = 4'h0;

   // page register fields
   localparam int PG_CAL_HI = 5;
   localparam int PG_CAL_LO = 4;
   localparam int PG_STR_HI = 3;
   localparam int PG_STR_LO = 0;

   // gain register fields
   localparam int GN_PHASE  = 7;
   localparam int GN_AGC_HI = 6;
   localparam int GN_AGC_LO = 4;
   localparam int GN_CHAN   = 3;
   localparam int GN_CARR   = 2;
   localparam int GN_PLL    = 1;
   localparam int GN_OSC    = 0;

   // strength page codes
   localparam logic [3:0] STR_REALTIME = 4'h0;
   localparam logic [3:0] STR_NOISE    = 4'h2;
   localparam logic [3:0] STR_PILOT    = 4'h4;
   localparam logic [3:0] STR_DATA     = 4'h6;
   localparam logic [3:0] STR_PEAK     = 4'h8;
   localparam logic [3:0] STR_ICD_TIME = 4'hc;
   localparam logic [3:0] STR_ICD_LEN  = 4'hd;
   localparam logic [3:0] STR_ERR_TIME = 4'he;

   // cal/level page codes
   localparam logic [1:0] CAL_ATTEN = 2'h0;
   localparam logic [1:0] CAL_VCO   = 2'h1;
   localparam logic [1:0] RSV_ZERO  = 2'h0;
   localparam logic       VCO_ONE   = 1'b1;

   // interrupt status bits
   localparam int EV_CARR_LOST = 0;
   localparam int EV_PLL_LOST  = 1;
   localparam int EV_OSC_UP    = 2;
   localparam int EV_CHAN_SEL  = 3;
   localparam int EV_N         = 4;
endpackage : rsd_pkg

//--- core/rsd_status_regs.sv
// apb register bank showing reader gain, health, strength and calibration status
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rsd_status_regs #(
   parameter int ADDR_W = 10
) (
   input  wire  logic              pclk,
   input  wire  logic              presetn,
   input  wire  logic              psel,
   input  wire  logic              penable,
   input  wire  logic              pwrite,
   input  wire  logic [ADDR_W-1:0] paddr,
   input  wire  logic [31:0]       pwdata,
   output logic       [31:0]       prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire  logic              subc_in_phase,
   input  wire  logic [2:0]        agc_step,
   input  wire  logic              dec_chan,
   input  wire  logic              rx_start,
   input  wire  logic              tx_start,
   input  wire  logic              carrier_stable_flag,
   input  wire  logic              pll_lock_raw,
   input  wire  logic              osc_stable_raw,
   input  wire  logic [7:0]        rssi_realtime,
   input  wire  logic [7:0]        rssi_noise,
   input  wire  logic [7:0]        rssi_pilot,
   input  wire  logic [7:0]        rssi_data,
   input  wire  logic [7:0]        rssi_peak,
   input  wire  logic [7:0]        icd_time,
   input  wire  logic [7:0]        icd_length,
   input  wire  logic [7:0]        err_time,
   input  wire  logic [2:0]        atten_q,
   input  wire  logic [2:0]        atten_i,
   input  wire  logic [3:0]        vco_range,
   input  wire  logic [2:0]        vco_volt,
   output logic                    irq
);

   if (ADDR_W < 10) begin : g_bad_addr
      $error("ADDR_W must be at least 10");
   end

   localparam int NF = 3;

   // health flags come from analog blocks: two-flop synchronisers
   logic [NF-1:0] raw_flags;
   logic [NF-1:0] sync1_q;
   logic [NF-1:0] sync2_q;
   logic [NF-1:0] prev_q;

   assign raw_flags = {carrier_stable_flag, pll_lock_raw, osc_stable_raw};

   for (genvar i = 0; i < NF; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
            prev_q[i]  <= 1'b0;
         end else begin
            sync1_q[i] <= raw_flags[i];
            sync2_q[i] <= sync1_q[i];
            prev_q[i]  <= sync2_q[i];
         end
      end
   end

   logic carr_ok;
   logic pll_ok;
   logic osc_ok;
   assign carr_ok = sync2_q[2];
   assign pll_ok  = sync2_q[1];
   assign osc_ok  = sync2_q[0];

   // decoder channel latched at reception start, held through tx
   logic in_sel_q;
   logic in_sel_d;
   assign in_sel_d = rx_start ? dec_chan : in_sel_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sel_q <= 1'b0;
      end else begin
         in_sel_q <= in_sel_d;
      end
   end

   // address decode
   logic [7:0] idx;
   logic       aligned;
   logic       hit_page;
   logic       hit_gain;
   logic       hit_rssi;
   logic       hit_cal;
   logic       hit_st;
   logic       hit_msk;
   logic       hit_any;
   logic       setup;
   logic       wr_en;

   assign idx      = paddr[9:2];
   assign aligned  = paddr[1:0] == rsd_pkg::WORD_ALIGN;
   assign hit_page = aligned && idx == rsd_pkg::IDX_PAGE;
   assign hit_gain = aligned && idx == rsd_pkg::IDX_GAIN;
   assign hit_rssi = aligned && idx == rsd_pkg::IDX_RSSI;
   assign hit_cal  = aligned && idx == rsd_pkg::IDX_CAL;
   assign hit_st   = aligned && idx == rsd_pkg::IDX_IRQ_ST;
   assign hit_msk  = aligned && idx == rsd_pkg::IDX_IRQ_MSK;
   assign hit_any  = hit_page | hit_gain | hit_rssi | hit_cal | hit_st | hit_msk;
   assign setup    = psel && !penable;
   assign wr_en    = psel && penable && pwrite && pready;

   // page register and interrupt registers
   logic [7:0]            page_q;
   logic [7:0]            page_d;
   logic [rsd_pkg::EV_N-1:0] mask_q;
   logic [rsd_pkg::EV_N-1:0] mask_d;
   logic [rsd_pkg::EV_N-1:0] st_q;
   logic [rsd_pkg::EV_N-1:0] st_d;
   logic [rsd_pkg::EV_N-1:0] ev;
   logic [rsd_pkg::EV_N-1:0] st_clr;

   // status display addresses have no write path at all
   assign page_d = (wr_en && hit_page) ? pwdata[7:0] : page_q;
   assign mask_d = (wr_en && hit_msk) ? pwdata[rsd_pkg::EV_N-1:0] : mask_q;
   assign st_clr = (wr_en && hit_st) ? pwdata[rsd_pkg::EV_N-1:0] : '0;

   assign ev[rsd_pkg::EV_CARR_LOST] = prev_q[2] && !carr_ok;
   assign ev[rsd_pkg::EV_PLL_LOST]  = prev_q[1] && !pll_ok;
   assign ev[rsd_pkg::EV_OSC_UP]    = !prev_q[0] && osc_ok;
   assign ev[rsd_pkg::EV_CHAN_SEL]  = rx_start;

   // a new event outranks a clear in the same cycle
   assign st_d = (st_q & ~st_clr) | ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= rsd_pkg::PAGE_RESET;
         mask_q <= rsd_pkg::MASK_RESET;
         st_q   <= '0;
         irq    <= 1'b0;
      end else begin
         page_q <= page_d;
         mask_q <= mask_d;
         st_q   <= st_d;
         irq    <= |(st_d & mask_d);
      end
   end

   // page fields
   logic [1:0] cal_level_page_field;
   logic [3:0] strength_page_field;
   assign cal_level_page_field = page_q[rsd_pkg::PG_CAL_HI:rsd_pkg::PG_CAL_LO];
   assign strength_page_field  = page_q[rsd_pkg::PG_STR_HI:rsd_pkg::PG_STR_LO];

   // gain and health view
   logic [7:0] rd_gain;
   assign rd_gain[rsd_pkg::GN_PHASE] = subc_in_phase;
   assign rd_gain[rsd_pkg::GN_AGC_HI:rsd_pkg::GN_AGC_LO] = agc_step;
   assign rd_gain[rsd_pkg::GN_CHAN] = in_sel_q;
   assign rd_gain[rsd_pkg::GN_CARR] = carr_ok;
   assign rd_gain[rsd_pkg::GN_PLL]  = pll_ok;
   assign rd_gain[rsd_pkg::GN_OSC]  = osc_ok;

   // strength view: inputs already carry Q high nibble, I low nibble
   logic [7:0] rd_rssi;
   assign rd_rssi =
      (strength_page_field == rsd_pkg::STR_REALTIME) ? rssi_realtime :
      (strength_page_field == rsd_pkg::STR_NOISE)    ? rssi_noise    :
      (strength_page_field == rsd_pkg::STR_PILOT)    ? rssi_pilot    :
      (strength_page_field == rsd_pkg::STR_DATA)     ? rssi_data     :
      (strength_page_field == rsd_pkg::STR_PEAK)     ? rssi_peak     :
      (strength_page_field == rsd_pkg::STR_ICD_TIME) ? icd_time      :
      (strength_page_field == rsd_pkg::STR_ICD_LEN)  ? icd_length    :
      (strength_page_field == rsd_pkg::STR_ERR_TIME) ? err_time      :
      8'h00;

   // paged calibration/level view; pages above 01 read zero here
   logic [7:0] rd_atten;
   logic [7:0] vco_range_and_voltage;
   logic [7:0] rd_cal;
   assign rd_atten = {rsd_pkg::RSV_ZERO, atten_q, atten_i};
   assign vco_range_and_voltage = {vco_range, rsd_pkg::VCO_ONE, vco_volt};
   assign rd_cal =
      (cal_level_page_field == rsd_pkg::CAL_ATTEN) ? rd_atten :
      (cal_level_page_field == rsd_pkg::CAL_VCO)   ? vco_range_and_voltage :
      8'h00;

   logic [31:0] rd_word;
   assign rd_word =
      hit_page ? {24'h000000, page_q} :
      hit_gain ? {24'h000000, rd_gain} :
      hit_rssi ? {24'h000000, rd_rssi} :
      hit_cal  ? {24'h000000, rd_cal} :
      hit_st   ? {28'h0000000, st_q} :
      hit_msk  ? {28'h0000000, mask_q} :
      32'h00000000;

   // apb answer: data sampled in setup, ready in first access cycle
   logic        rdy_d;
   logic [31:0] prdata_d;
   logic        err_d;
   assign rdy_d    = setup;
   assign prdata_d = (setup && !pwrite) ? rd_word : prdata;
   assign err_d    = setup ? !hit_any : (pready ? 1'b0 : pslverr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rdy_d;
         prdata  <= prdata_d;
         pslverr <= err_d;
      end
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_rd(logic h);
      setup && !pwrite && h;
   endsequence

   sequence s_wr(logic h);
      setup && pwrite && h ##1 penable && pready;
   endsequence

   chk_gain_phase: assert property (
      s_rd(hit_gain) |=> prdata[7] == $past(subc_in_phase))
      else $error("phase bit wrong");

   chk_gain_step: assert property (
      s_rd(hit_gain) |=> prdata[6:4] == $past(agc_step) && pready)
      else $error("gain step wrong");

   chk_chan_hold: assert property (
      rx_start ##1 (!rx_start)[*3] |-> in_sel_q == $past(dec_chan, 3))
      else $error("channel select not held");

   chk_carrier_sync: assert property (
      carrier_stable_flag[*3] |=> rd_gain[2])
      else $error("carrier flag missing");

   chk_pll_sync: assert property (
      (!pll_lock_raw)[*3] |=> !rd_gain[1])
      else $error("lock flag stuck");

   chk_osc_sync: assert property (
      $rose(osc_stable_raw) ##1 osc_stable_raw |=> osc_ok)
      else $error("osc flag late");

   chk_rssi_rt: assert property (
      s_rd(hit_rssi && strength_page_field == rsd_pkg::STR_REALTIME)
      |=> prdata[7:0] == $past(rssi_realtime))
      else $error("realtime strength wrong");

   chk_rssi_unused: assert property (
      s_rd(hit_rssi && strength_page_field == 4'h1) |=> prdata[7:0] == 8'h00)
      else $error("unused strength code not zero");

   chk_page0_view: assert property (
      s_rd(hit_cal && cal_level_page_field == rsd_pkg::CAL_ATTEN)
      |=> prdata[7:0] == {2'b00, $past(atten_q), $past(atten_i)})
      else $error("attenuation page wrong");

   chk_page1_view: assert property (
      s_rd(hit_cal && cal_level_page_field == rsd_pkg::CAL_VCO)
      |=> prdata[3] && prdata[7:4] == $past(vco_range) && prdata[2:0] == $past(vco_volt))
      else $error("vco page wrong");

   chk_page_field: assert property (
      s_wr(hit_page) |=> cal_level_page_field == $past(pwdata[5:4]))
      else $error("page field not written");

   chk_ro_ignore: assert property (
      s_wr(hit_gain || hit_rssi || hit_cal) |=> $stable(page_q) && $stable(mask_q))
      else $error("status write changed state");

   chk_irq_level: assert property (
      ##1 irq == |($past(st_d) & $past(mask_d)))
      else $error("irq mismatch");

   // bus answer: one ready pulse right after setup, error only for unmapped or misaligned addresses
   chk_ready_timing: assert property (
      setup |=> pready)
      else $error("ready not in first access cycle");

   chk_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready held too long");

   chk_err_unmapped: assert property (
      setup && !hit_any |=> pready && pslverr)
      else $error("unmapped access not refused");

   chk_err_mapped: assert property (
      setup && hit_any |=> !pslverr)
      else $error("mapped access refused");

   chk_rd_upper: assert property (
      setup && !pwrite |=> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");

   // channel choice must survive the start of a transmission
   chk_chan_tx_hold: assert property (
      tx_start && !rx_start |=> $stable(in_sel_q))
      else $error("channel select lost at tx start");

   chk_rssi_noise: assert property (
      s_rd(hit_rssi && strength_page_field == rsd_pkg::STR_NOISE)
      |=> prdata[7:0] == $past(rssi_noise))
      else $error("noise strength wrong");

   chk_rssi_peak: assert property (
      s_rd(hit_rssi && strength_page_field == rsd_pkg::STR_PEAK)
      |=> prdata[7:0] == $past(rssi_peak))
      else $error("peak strength wrong");

   chk_rssi_err_time: assert property (
      s_rd(hit_rssi && strength_page_field == rsd_pkg::STR_ERR_TIME)
      |=> prdata[7:0] == $past(err_time))
      else $error("violation time wrong");

   chk_cal_other: assert property (
      s_rd(hit_cal && cal_level_page_field[1])
      |=> prdata[7:0] == 8'h00)
      else $error("undefined cal page not zero");

   // a reception start always lands in status, even against a clear
   chk_rx_event: assert property (
      rx_start |=> st_q[rsd_pkg::EV_CHAN_SEL] && (irq || !mask_q[rsd_pkg::EV_CHAN_SEL]))
      else $error("rx start event lost");

endmodule : rsd_status_regs
`default_nettype wire

//--- verification/rsd_host_model.sv
// apb master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module rsd_host_model (
   input  wire logic        pclk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [9:0]  paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 10'h000;
      pwdata  = 32'h0000_0000;
   end
   // one full transfer; request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : rsd_host_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the status display register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [9:0] A_PAGE = {rsd_pkg::IDX_PAGE, rsd_pkg::WORD_ALIGN};
   localparam logic [9:0] A_GAIN = {rsd_pkg::IDX_GAIN, rsd_pkg::WORD_ALIGN};
   localparam logic [9:0] A_RSSI = {rsd_pkg::IDX_RSSI, rsd_pkg::WORD_ALIGN};
   localparam logic [9:0] A_CAL  = {rsd_pkg::IDX_CAL, rsd_pkg::WORD_ALIGN};
   localparam logic [9:0] A_ST   = {rsd_pkg::IDX_IRQ_ST, rsd_pkg::WORD_ALIGN};
   localparam logic [9:0] A_MSK  = {rsd_pkg::IDX_IRQ_MSK, rsd_pkg::WORD_ALIGN};
   logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic subc = 1'b0, chan = 1'b0, rxs = 1'b0, txs = 1'b0, carr = 1'b1, pll = 1'b0;
   logic osc = 1'b0;
   logic [2:0] agc = 3'h0, aq = 3'h3, ai = 3'h4, vv = 3'h5;
   logic [3:0] vr = 4'ha;
   logic [7:0] rs [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf1};
   logic [3:0] codes [9] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc, 4'hd, 4'he, 4'h1};
   int n_errors = 0, total_checks = 0, cycles = 0;
   logic [31:0] d;
   logic e;
   initial forever #12.5 pclk = ~pclk;
   rsd_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   rsd_status_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .subc_in_phase(subc), .agc_step(agc), .dec_chan(chan),
      .rx_start(rxs), .tx_start(txs), .carrier_stable_flag(carr), .pll_lock_raw(pll),
      .osc_stable_raw(osc), .rssi_realtime(rs[0]), .rssi_noise(rs[1]), .rssi_pilot(rs[2]),
      .rssi_data(rs[3]), .rssi_peak(rs[4]), .icd_time(rs[5]), .icd_length(rs[6]),
      .err_time(rs[7]), .atten_q(aq), .atten_i(ai), .vco_range(vr), .vco_volt(vv),
      .irq(irq));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rd(input string name, input logic [9:0] a, input logic [31:0] exp,
                     input logic experr);
      u_host.xfer(1'b0, a, 32'h0, d, e);
      chk(name, exp, d);
      chk({name, " error"}, {31'h0, experr}, {31'h0, e});
   endtask : rd
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      u_host.xfer(1'b1, a, v, d, e);
   endtask : wr
   task automatic pulse_rx;
      @(posedge pclk);
      rxs <= 1'b1;
      @(posedge pclk);
      rxs <= 1'b0;
   endtask : pulse_rx
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         $display("ERROR timeout expected done seen hang");
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("page reset", A_PAGE, 32'h0, 1'b0);
      rd("mask reset", A_MSK, 32'h0, 1'b0);
      // health, gain and phase read live; only channel latched at rx start
      subc <= 1'b1;
      agc  <= 3'h5;
      chan <= 1'b1;
      osc  <= 1'b1;
      pulse_rx();
      repeat (5) @(posedge pclk);
      rd("gain a", A_GAIN, 32'hdd, 1'b0);
      txs  <= 1'b1;
      chan <= 1'b0;
      @(posedge pclk);
      txs <= 1'b0;
      rd("chan held", A_GAIN, 32'hdd, 1'b0);
      subc <= 1'b0;
      agc  <= 3'h2;
      carr <= 1'b0;
      pll  <= 1'b1;
      pulse_rx();
      repeat (5) @(posedge pclk);
      rd("gain b", A_GAIN, 32'h23, 1'b0);
      // every strength page code, last one unlisted
      for (int k = 0; k < 9; k++) begin
         wr(A_PAGE, {28'h0, codes[k]});
         rd("strength", A_RSSI, (k < 8) ? {24'h0, rs[k]} : 32'h0, 1'b0);
      end
      wr(A_PAGE, 32'h00);
      rd("cal page0", A_CAL, 32'h1c, 1'b0);
      wr(A_PAGE, 32'h10);
      rd("cal page1", A_CAL, 32'had, 1'b0);
      wr(A_PAGE, 32'h20);
      rd("cal page2", A_CAL, 32'h0, 1'b0);
      rd("page rw", A_PAGE, 32'h20, 1'b0);
      // writes to the display registers change nothing
      wr(A_GAIN, 32'hff);
      chk("write err", 32'h0, {31'h0, e});
      wr(A_RSSI, 32'hff);
      wr(A_CAL, 32'hff);
      rd("gain kept", A_GAIN, 32'h23, 1'b0);
      rd("cal kept", A_CAL, 32'h0, 1'b0);
      rd("page kept", A_PAGE, 32'h20, 1'b0);
      rd("unmapped", 10'h3fc, 32'h0, 1'b1);
      rd("misaligned", 10'h0a9, 32'h0, 1'b1);
      // carrier loss event: masked, unmasked, cleared
      u_host.xfer(1'b0, A_ST, 32'h0, d, e);
      chk("carrier lost", 32'h1, d & 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(A_MSK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq on", 32'h1, {31'h0, irq});
      wr(A_ST, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq off", 32'h0, {31'h0, irq});
      wr(A_ST, 32'hf);
      wr(A_MSK, 32'h8);
      repeat (2) @(posedge pclk);
      chk("irq idle", 32'h0, {31'h0, irq});
      pulse_rx();
      repeat (3) @(posedge pclk);
      chk("irq rx", 32'h1, {31'h0, irq});
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
